/* rtl/current_adc_a_pkg.sv */
// Package for the first current converter channel configuration block.
// Assumes a single 20 MHz clock domain and a 32-bit classic Wishbone register bus.
package current_adc_a_pkg;

  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0] SETUP_INDEX      = 8'h82;
  localparam logic [7:0] INPUT_INDEX      = 8'h83;
  localparam logic [7:0] TRIM_HIGH_INDEX  = 8'h84;
  localparam logic [7:0] CONTROL_INDEX    = 8'h90;
  localparam logic [7:0] STATUS_INDEX     = 8'h91;
  localparam logic [7:0] RESULT_INDEX     = 8'h92;

  // Values after reset.
  localparam logic [15:0] SETUP_RESET     = 16'h0400;
  localparam logic [15:0] INPUT_RESET     = 16'h8010;
  localparam logic [15:0] TRIM_RESET      = 16'h0000;

  // Writable bit masks; reserved bits are cleared by these.
  localparam logic [15:0] SETUP_MASK      = 16'h0F0F;
  localparam logic [15:0] INPUT_MASK      = 16'h8F3F;

  // Field positions in the conversion setup register.
  localparam int MODE_BIT                 = 11;
  localparam int OSR_LSB                  = 8;
  localparam int CHOP_BIT                 = 3;
  localparam int DELAY_LSB                = 0;

  // Field positions in the input setup register.
  localparam int ENABLE_BIT               = 15;
  localparam int GAIN_LSB                 = 10;
  localparam int ROUTE_LSB                = 8;
  localparam int SOURCE_PIN_BIT           = 5;
  localparam int SINK_PIN_BIT             = 4;
  localparam int SOURCE_LVL_LSB           = 2;
  localparam int SINK_LVL_LSB             = 0;

  // Base counts in modulator periods.
  localparam logic [13:0] OSR_BASE        = 14'h0040;
  localparam logic [8:0]  DELAY_BASE      = 9'h002;

  // Analog gain ceiling; higher gains are finished digitally.
  localparam logic [5:0]  ANALOG_GAIN_MAX = 6'h08;

  // Input routing codes.
  localparam logic [1:0] ROUTE_NORMAL     = 2'h0;
  localparam logic [1:0] ROUTE_SWAPPED    = 2'h1;
  localparam logic [1:0] ROUTE_SHORTED    = 2'h2;
  localparam logic [1:0] ROUTE_TEST_DAC   = 2'h3;

endpackage : current_adc_a_pkg

/* rtl/conversion_sequencer.sv */
// Conversion sequencer: paces conversions and chop settling in modulator ticks.
// Assumes modTick pulses once per modulator period, synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module conversion_sequencer
  import current_adc_a_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Timing control.
  input  wire logic        modTick,
  input  wire logic        running,
  input  wire logic        singleShot,
  input  wire logic        startPulse,
  input  wire logic [13:0] ratio,
  input  wire logic        chopOn,
  input  wire logic [8:0]  settle,
  // Events.
  output logic             convDone,
  output logic             busy
);
  // Sequencer phases.
  typedef enum logic [1:0] {IDLE, SETTLE, CONVERT} phase_type;
  typedef struct packed {
    phase_type   phase;
    logic [13:0] count;
    logic        done;
  } seq_type;
  seq_type s_reg, s_next;

  // One process plans the next phase; single-shot halts after one result.
  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (!running)
    begin
      s_next.phase = IDLE;
      s_next.count = 14'h0000;
    end
    else
    begin
      case (s_reg.phase)
        IDLE:
        begin
          if (!singleShot || startPulse) // [R18]
          begin
            s_next.phase = chopOn ? SETTLE : CONVERT; // [R03]
            s_next.count = 14'h0000;
          end
        end
        SETTLE:
        begin
          if (modTick)
          begin
            if (s_reg.count + 14'h0001 >= {5'h00, settle}) // [R04]
            begin
              s_next.phase = CONVERT;
              s_next.count = 14'h0000;
            end
            else
              s_next.count = s_reg.count + 14'h0001;
          end
        end
        CONVERT:
        begin
          if (modTick)
          begin
            if (s_reg.count + 14'h0001 >= ratio) // [R02]
            begin
              s_next.done = 1'b1;
              s_next.count = 14'h0000;
              s_next.phase = singleShot ? IDLE : (chopOn ? SETTLE : CONVERT); // [R01]
            end
            else
              s_next.count = s_reg.count + 14'h0001;
          end
        end
        default:
          s_next.phase = IDLE;
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (rst)
      s_reg <= '{phase: IDLE, count: 14'h0000, done: 1'b0};
    else
      s_reg <= s_next;
  end

  assign convDone = s_reg.done;
  assign busy     = (s_reg.phase != IDLE);

  // A disabled channel never reports a finished conversion.
  a_idle_when_off: assert property (@(posedge clk) disable iff (rst)
    !running |=> !convDone) else $error("conversion finished while stopped"); // [R05]
endmodule : conversion_sequencer
`default_nettype wire

/* rtl/current_adc_a_config_regs.sv */
// Configuration registers of current converter channel A with a Wishbone slave.
// Assumes classic Wishbone, 32-bit data, one clock at 20 MHz, synchronous reset.
//
// Summary of operation
// [R01] Mode bit: 0 continuous, 1 single shot.
// [R02] Ratio is 64 shifted by code.
// [R03] Chop only while chop enable set.
// [R04] Settle delay 2 shifted by code.
// [R05] Disable or standby clears result, counter.
// [R06] Gain code gives 4, 8, 16, 32.
// [R07] Gains above 8 finish digitally.
// [R08] Route: normal, swapped, shorted, test DAC.
// [R09] Source pin select: positive or negative.
// [R10] Sink pin select, resets to negative.
// [R11] Source level off, 4, 40, 240.
// [R12] Sink level uses same steps.
// [R13] Trim high word at 84h, resets zero.
// [R14] Conversion setup resets to 0400h.
// [R15] Input setup resets to 8010h.
// [R16] Trim value is signed 24-bit.
// [R17] Reserved bits read zero, ignore writes.
// [R18] Single shot: one conversion per start.
`timescale 1ns/1ps
`default_nettype none
module current_adc_a_config_regs
  import current_adc_a_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Device power state and modulator timing.
  input  wire logic        standby,
  input  wire logic        modTick,
  // Raw result from the modulator filter.
  input  wire logic [23:0] filterData,
  // Analog controls.
  output logic             chopActive,
  output logic [1:0]       inputRoute,
  output logic [5:0]       analogGain,
  output logic [2:0]       digitalShift,
  output logic             sourceOnNegative,
  output logic             sinkOnNegative,
  output logic [1:0]       sourceLevel,
  output logic [1:0]       sinkLevel,
  output logic signed [23:0] offsetTrim,
  output logic [13:0]      oversampleRatio,
  output logic [8:0]       settleTicks,
  // Conversion outputs.
  output logic [23:0]      conversionResult,
  output logic [1:0]       conversionCounter
);
  import current_adc_a_pkg::*;

  // Module state other than the sequencer instance in one packed record.
  typedef struct packed {
    logic [15:0] setup;
    logic [15:0] inputs;
    logic [15:0] trim;
    logic        start;
    logic [23:0] result;
    logic [1:0]  counter;
    logic        ack;
    logic [31:0] rdata;
    logic        chop;
    logic [1:0]  route;
    logic [5:0]  aGain;
    logic [2:0]  dShift;
    logic        srcPin;
    logic        snkPin;
    logic [1:0]  srcLvl;
    logic [1:0]  snkLvl;
    logic [13:0] ratio;
    logic [8:0]  settle;
  } state_type;
  state_type st_reg, st_next;

  // Sequencer handshake and bus decode.
  logic convDone;
  logic seqBusy;
  logic running;
  logic [7:0] index;
  logic       access;

  assign index   = wb_adr_i[9:2];
  assign access  = wb_cyc_i && wb_stb_i && !st_reg.ack;
  // Standby or a cleared enable stops the channel.
  assign running = st_reg.inputs[ENABLE_BIT] && !standby;

  conversion_sequencer u_seq (
    .clk       (clk),
    .rst       (rst),
    .modTick   (modTick),
    .running   (running),
    .singleShot(st_reg.setup[MODE_BIT]),
    .startPulse(st_reg.start),
    .ratio     (st_reg.ratio),
    .chopOn    (st_reg.chop),
    .settle    (st_reg.settle),
    .convDone  (convDone),
    .busy      (seqBusy)
  );

  // Byte-lane merge of a 16-bit register with a writable mask.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (sel[0])
      v[7:0] = d[7:0];
    if (sel[1])
      v[15:8] = d[15:8];
    return v & mask; // [R17]
  endfunction : merge16

  // Next-state logic: bus decode, field decode and result capture.
  always_comb
  begin
    st_next = st_reg;
    st_next.start = 1'b0;
    // Ack drops the cycle after it was given.
    st_next.ack = access;
    if (access && wb_we_i)
    begin
      case (index)
        SETUP_INDEX:
          st_next.setup = merge16(st_reg.setup, wb_dat_i, wb_sel_i, SETUP_MASK); // [R17]
        INPUT_INDEX:
          st_next.inputs = merge16(st_reg.inputs, wb_dat_i, wb_sel_i, INPUT_MASK); // [R17]
        TRIM_HIGH_INDEX:
          st_next.trim = merge16(st_reg.trim, wb_dat_i, wb_sel_i, 16'hFFFF); // [R13]
        CONTROL_INDEX:
          st_next.start = wb_sel_i[0] && wb_dat_i[0]; // [R18]
        default:
          st_next.start = 1'b0;
      endcase
    end
    if (access && !wb_we_i)
    begin
      case (index)
        SETUP_INDEX:     st_next.rdata = {16'h0000, st_reg.setup};
        INPUT_INDEX:     st_next.rdata = {16'h0000, st_reg.inputs};
        TRIM_HIGH_INDEX: st_next.rdata = {16'h0000, st_reg.trim};
        STATUS_INDEX:    st_next.rdata = {29'h00000000, st_reg.counter, seqBusy};
        RESULT_INDEX:    st_next.rdata = {8'h00, st_reg.result};
        // Unmapped addresses still ack so a stray access cannot hang the bus.
        default:         st_next.rdata = 32'h00000000;
      endcase
    end
    // Results count up while running and clear on disable or standby.
    if (!running)
    begin
      st_next.result  = 24'h000000; // [R05]
      st_next.counter = 2'h0; // [R05]
    end
    else if (convDone)
    begin
      st_next.result  = filterData;
      st_next.counter = st_reg.counter + 2'h1;
    end
    // Decoded controls, registered so outputs come from flip-flops.
    st_next.chop   = st_reg.setup[CHOP_BIT]; // [R03]
    st_next.ratio  = OSR_BASE << st_reg.setup[OSR_LSB +: 3]; // [R02]
    st_next.settle = DELAY_BASE << st_reg.setup[DELAY_LSB +: 3]; // [R04]
    st_next.route  = st_reg.inputs[ROUTE_LSB +: 2]; // [R08]
    // Gain 4 or 8 is analog; 16 and 32 keep analog 8 and shift digitally.
    case (st_reg.inputs[GAIN_LSB +: 2])
      2'h0:
      begin
        st_next.aGain  = 6'h04; // [R06]
        st_next.dShift = 3'h0;
      end
      2'h1:
      begin
        st_next.aGain  = ANALOG_GAIN_MAX; // [R06]
        st_next.dShift = 3'h0;
      end
      2'h2:
      begin
        st_next.aGain  = ANALOG_GAIN_MAX; // [R07]
        st_next.dShift = 3'h1;
      end
      default:
      begin
        st_next.aGain  = ANALOG_GAIN_MAX; // [R07]
        st_next.dShift = 3'h2;
      end
    endcase
    st_next.srcPin = st_reg.inputs[SOURCE_PIN_BIT]; // [R09]
    st_next.snkPin = st_reg.inputs[SINK_PIN_BIT]; // [R10]
    st_next.srcLvl = st_reg.inputs[SOURCE_LVL_LSB +: 2]; // [R11]
    st_next.snkLvl = st_reg.inputs[SINK_LVL_LSB +: 2]; // [R12]
  end

  // State register with synchronous reset to documented defaults.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg        <= '0;
      st_reg.setup  <= SETUP_RESET; // [R14]
      st_reg.inputs <= INPUT_RESET; // [R15]
      st_reg.trim   <= TRIM_RESET; // [R13]
      st_reg.ratio  <= OSR_BASE << SETUP_RESET[OSR_LSB +: 3];
      st_reg.settle <= DELAY_BASE;
      st_reg.aGain  <= 6'h04;
      st_reg.snkPin <= 1'b1; // [R10]
    end
    else
      st_reg <= st_next;
  end

  // Output drive, every one from a flip-flop.
  assign wb_ack_o          = st_reg.ack;
  assign wb_dat_o          = st_reg.rdata;
  assign chopActive        = st_reg.chop;
  assign inputRoute        = st_reg.route;
  assign analogGain        = st_reg.aGain;
  assign digitalShift      = st_reg.dShift;
  assign sourceOnNegative  = st_reg.srcPin;
  assign sinkOnNegative    = st_reg.snkPin;
  assign sourceLevel       = st_reg.srcLvl;
  assign sinkLevel         = st_reg.snkLvl;
  // Trim is signed; low byte is held elsewhere and reads as zero here.
  assign offsetTrim        = {st_reg.trim, 8'h00}; // [R16]
  assign oversampleRatio   = st_reg.ratio;
  assign settleTicks       = st_reg.settle;
  assign conversionResult  = st_reg.result;
  assign conversionCounter = st_reg.counter;

  // Checks.
  a_result_cleared: assert property (@(posedge clk) disable iff (rst)
    !running |=> (conversionResult == 24'h000000 && conversionCounter == 2'h0))
    else $error("result not cleared when stopped"); // [R05]
  a_ratio_decode: assert property (@(posedge clk) disable iff (rst)
    ##1 (oversampleRatio == (OSR_BASE << $past(st_reg.setup[OSR_LSB +: 3]))))
    else $error("ratio decode wrong"); // [R02]
  a_settle_decode: assert property (@(posedge clk) disable iff (rst)
    ##1 (settleTicks == (DELAY_BASE << $past(st_reg.setup[DELAY_LSB +: 3]))))
    else $error("settle decode wrong"); // [R04]
  a_gain_ceiling: assert property (@(posedge clk) disable iff (rst)
    (st_reg.inputs[GAIN_LSB +: 2] == 2'h3) |=> (analogGain == 6'h08 && digitalShift == 3'h2))
    else $error("gain 32 split wrong"); // [R07]
  a_gain_low: assert property (@(posedge clk) disable iff (rst)
    (st_reg.inputs[GAIN_LSB +: 2] == 2'h0) |=> (analogGain == 6'h04 && digitalShift == 3'h0))
    else $error("gain 4 wrong"); // [R06]
  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    ((st_reg.setup & ~SETUP_MASK) == 16'h0000) && ((st_reg.inputs & ~INPUT_MASK) == 16'h0000))
    else $error("reserved bit set"); // [R17]
  a_chop_follow: assert property (@(posedge clk) disable iff (rst)
    st_reg.setup[CHOP_BIT] |=> chopActive) else $error("chop not applied"); // [R03]
  a_route_follow: assert property (@(posedge clk) disable iff (rst)
    ##1 (inputRoute == $past(st_reg.inputs[ROUTE_LSB +: 2])))
    else $error("route mismatch"); // [R08]
  a_pins_follow: assert property (@(posedge clk) disable iff (rst)
    ##1 (sourceOnNegative == $past(st_reg.inputs[SOURCE_PIN_BIT])
      && sinkOnNegative == $past(st_reg.inputs[SINK_PIN_BIT])))
    else $error("pin select mismatch"); // [R09]
  a_levels_follow: assert property (@(posedge clk) disable iff (rst)
    ##1 (sourceLevel == $past(st_reg.inputs[SOURCE_LVL_LSB +: 2])
      && sinkLevel == $past(st_reg.inputs[SINK_LVL_LSB +: 2])))
    else $error("level mismatch"); // [R11]
  a_ack_one: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  a_trim_write: assert property (@(posedge clk) disable iff (rst)
    (access && wb_we_i && index == TRIM_HIGH_INDEX && wb_sel_i == 4'hF)
    |=> (offsetTrim[23:8] == $past(wb_dat_i[15:0]))) else $error("trim write lost"); // [R13]
  // A finished conversion while running captures the filter word and counts once.
  a_result_capture: assert property (@(posedge clk) disable iff (rst) // [R01]
    (running && convDone) |=> (conversionResult == $past(filterData)
      && conversionCounter == $past(conversionCounter) + 2'h1))
    else $error("result capture wrong");
  // Between conversions the held result must not drift.
  a_result_hold: assert property (@(posedge clk) disable iff (rst) // [R01]
    (running && !convDone) |=> $stable(conversionResult))
    else $error("result changed without conversion");
  // Every taken request is answered on the following edge.
  a_ack_answer: assert property (@(posedge clk) disable iff (rst)
    access |=> wb_ack_o) else $error("request not acknowledged");
  // No acknowledge appears without a taken request.
  a_ack_cause: assert property (@(posedge clk) disable iff (rst)
    !access |=> !wb_ack_o) else $error("acknowledge without request");
  // Setup reads return the register with the upper half zero.
  a_setup_read: assert property (@(posedge clk) disable iff (rst) // [R17]
    (access && !wb_we_i && index == SETUP_INDEX)
    |=> (wb_dat_o == {16'h0000, $past(st_reg.setup)}))
    else $error("setup read data wrong");
  // Result reads leave the byte above the 24-bit word clear.
  a_result_read: assert property (@(posedge clk) disable iff (rst) // [R17]
    (access && !wb_we_i && index == RESULT_INDEX) |=> (wb_dat_o[31:24] == 8'h00))
    else $error("result read upper byte set");
  // A start pulse only follows a write to the control place.
  a_start_cause: assert property (@(posedge clk) disable iff (rst) // [R18]
    st_reg.start |-> $past(access && wb_we_i && index == CONTROL_INDEX))
    else $error("start without control write");
  // A full-word setup write lands with reserved bits dropped.
  a_setup_write: assert property (@(posedge clk) disable iff (rst) // [R17]
    (access && wb_we_i && index == SETUP_INDEX && wb_sel_i[1:0] == 2'h3)
    |=> (st_reg.setup == ($past(wb_dat_i[15:0]) & SETUP_MASK)))
    else $error("setup write wrong");
  // A full-word input write lands with reserved bits dropped.
  a_input_write: assert property (@(posedge clk) disable iff (rst) // [R17]
    (access && wb_we_i && index == INPUT_INDEX && wb_sel_i[1:0] == 2'h3)
    |=> (st_reg.inputs == ($past(wb_dat_i[15:0]) & INPUT_MASK)))
    else $error("input write wrong");
  // Gain code 1 is a plain analog gain of eight.
  a_gain_eight: assert property (@(posedge clk) disable iff (rst) // [R06]
    (st_reg.inputs[GAIN_LSB +: 2] == 2'h1) |=> (analogGain == 6'h08 && digitalShift == 3'h0))
    else $error("gain 8 wrong");
  // Gain code 2 keeps analog eight and doubles digitally.
  a_gain_mid: assert property (@(posedge clk) disable iff (rst) // [R07]
    (st_reg.inputs[GAIN_LSB +: 2] == 2'h2) |=> (analogGain == 6'h08 && digitalShift == 3'h1))
    else $error("gain 16 split wrong");
  // The analog stage never sees more than the ceiling.
  a_gain_range: assert property (@(posedge clk) disable iff (rst) // [R07]
    (analogGain == 6'h04 || analogGain == ANALOG_GAIN_MAX) && digitalShift <= 3'h2)
    else $error("gain out of range");
  // The low trim byte is not held here and must read as zero.
  a_trim_low: assert property (@(posedge clk) disable iff (rst) // [R16]
    offsetTrim[7:0] == 8'h00) else $error("trim low byte set");
  // Single shot stays halted until a start arrives.
  a_single_halt: assert property (@(posedge clk) disable iff (rst) // [R18]
    (st_reg.setup[MODE_BIT] && !seqBusy && !st_reg.start) |=> !seqBusy)
    else $error("single shot ran without start");
endmodule : current_adc_a_config_regs
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the channel A configuration registers.
// Assumes the design acks every Wishbone request and that modTick may be driven freely.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import current_adc_a_pkg::*;

  // A comparison counts once and reports a mismatch immediately.
  `define CHECK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin miscompares++; $display("wrong value at %0t: %s", $time, msg); end end

  // Clock, reset and stimulus.
  logic              clk         = 1'b0;
  logic              rst         = 1'b1;
  logic              wbCyc       = 1'b0;
  logic              wbStb       = 1'b0;
  logic              wbWe        = 1'b0;
  logic [11:0]       wbAdr       = 12'h000;
  logic [3:0]        wbSel       = 4'h0;
  logic [31:0]       wbDatI      = 32'h00000000;
  logic              standby     = 1'b0;
  logic              modTick     = 1'b0;
  logic [23:0]       filterData  = 24'h5A3C96;
  // Observed outputs.
  logic [31:0]       wbDatO;
  logic              wbAck;
  logic              chopActive, sourceOnNegative, sinkOnNegative;
  logic [1:0]        inputRoute, sourceLevel, sinkLevel, conversionCounter;
  logic [5:0]        analogGain;
  logic [2:0]        digitalShift;
  logic signed [23:0] offsetTrim;
  logic [13:0]       oversampleRatio;
  logic [8:0]        settleTicks;
  logic [23:0]       conversionResult;
  // Bookkeeping.
  int                miscompares = 0;
  int                checks      = 0;
  logic [31:0]       rdat;

  // Byte addresses are four times the register index.
  localparam logic [11:0] ADR_SETUP  = {2'b00, SETUP_INDEX, 2'b00};
  localparam logic [11:0] ADR_INPUT  = {2'b00, INPUT_INDEX, 2'b00};
  localparam logic [11:0] ADR_TRIM   = {2'b00, TRIM_HIGH_INDEX, 2'b00};
  localparam logic [11:0] ADR_CTRL   = {2'b00, CONTROL_INDEX, 2'b00};
  localparam logic [11:0] ADR_STATUS = {2'b00, STATUS_INDEX, 2'b00};
  localparam logic [11:0] ADR_RESULT = {2'b00, RESULT_INDEX, 2'b00};

  // The clock inverts every half period of 25 ns.
  always #25 clk = ~clk;

  // A modulator tick every other cycle keeps conversions short but not trivial.
  always @(posedge clk) modTick <= ~modTick;

  current_adc_a_config_regs DUT (
    .clk(clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .standby(standby), .modTick(modTick), .filterData(filterData),
    .chopActive(chopActive), .inputRoute(inputRoute), .analogGain(analogGain),
    .digitalShift(digitalShift), .sourceOnNegative(sourceOnNegative),
    .sinkOnNegative(sinkOnNegative), .sourceLevel(sourceLevel), .sinkLevel(sinkLevel),
    .offsetTrim(offsetTrim), .oversampleRatio(oversampleRatio),
    .settleTicks(settleTicks), .conversionResult(conversionResult),
    .conversionCounter(conversionCounter)
  );

  // One classic cycle; the request is held until ack is seen at a rising edge.
  task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbSel  <= 4'hF;
    wbDatI <= wd;
    // Only the watchdog ends a wait for a missing acknowledge.
    do
      @(posedge clk);
    while (wbAck !== 1'b1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask : bus

  // Write, then let the decoded outputs settle two edges later.
  task automatic wr(input logic [11:0] adr, input logic [15:0] d);
    logic [31:0] dummy;
    bus(1'b1, adr, {16'h0000, d}, dummy);
    repeat (2) @(posedge clk);
  endtask : wr

  task automatic rd(input logic [11:0] adr, output logic [31:0] d);
    bus(1'b0, adr, 32'h00000000, d);
  endtask : rd

  // Values seen straight after reset.
  task automatic test_reset();
    rd(ADR_SETUP, rdat);  `CHECK(rdat, 32'h00000400, "setup reset")
    rd(ADR_INPUT, rdat);  `CHECK(rdat, 32'h00008010, "input reset")
    rd(ADR_TRIM, rdat);   `CHECK(rdat, 32'h00000000, "trim reset")
    `CHECK(oversampleRatio, 14'h0400, "reset ratio")
    `CHECK(settleTicks, 9'h002, "reset settle")
    `CHECK(analogGain, 6'h04, "reset gain")
    `CHECK(sinkOnNegative, 1'b1, "reset sink pin")
    `CHECK(chopActive, 1'b0, "reset chop")
  endtask : test_reset

  // Every ratio and delay code, with reserved bits written as ones.
  task automatic test_setup();
    logic [2:0] c;
    for (int i = 0; i < 8; i++)
    begin
      c = 3'(i);
      wr(ADR_SETUP, 16'hF0F0 | {5'h00, c, 4'h0, c[0], ~c});
      `CHECK(oversampleRatio, 14'h0040 << c, "ratio decode")
      `CHECK(settleTicks, 9'h002 << (~c), "settle decode")
      `CHECK(chopActive, c[0], "chop enable")
      rd(ADR_SETUP, rdat);
      `CHECK(rdat, {21'h0, c, 4'h0, c[0], ~c}, "setup reserved bits")
    end
  endtask : test_setup

  // Every gain, route and level code; pins alternate per step.
  task automatic test_input();
    logic [1:0] g;
    for (int i = 0; i < 4; i++)
    begin
      g = 2'(i);
      wr(ADR_INPUT, 16'hF0C0 | {4'h0, g, g, 2'b00, g[0], ~g[0], g, ~g});
      `CHECK(analogGain, (g == 2'h0) ? 6'h04 : 6'h08, "analog gain")
      `CHECK(digitalShift, (g < 2'h2) ? 3'h0 : {1'b0, g - 2'h1}, "shift")
      `CHECK(inputRoute, g, "route")
      `CHECK(sourceOnNegative, g[0], "source pin")
      `CHECK(sinkOnNegative, ~g[0], "sink pin")
      `CHECK(sourceLevel, g, "source level")
      `CHECK(sinkLevel, ~g, "sink level")
      rd(ADR_INPUT, rdat);
      `CHECK(rdat, {16'h0, 4'h8, g, g, 2'b00, g[0], ~g[0], g, ~g}, "input readback")
    end
  endtask : test_input

  // Trim high word, a negative value, and an unmapped place that must stay empty.
  task automatic test_trim();
    wr(ADR_TRIM, 16'h8123);
    `CHECK(offsetTrim, 24'sh812300, "trim output")
    rd(ADR_TRIM, rdat);   `CHECK(rdat, 32'h00008123, "trim readback")
    wr(12'h3FC, 16'hFFFF);
    rd(12'h3FC, rdat);    `CHECK(rdat, 32'h00000000, "unmapped read")
  endtask : test_trim

  // Continuous run, disable clears, single shot waits for starts, standby clears.
  task automatic test_conversion();
    wr(ADR_SETUP, 16'h0000);
    wr(ADR_INPUT, 16'h8000);
    repeat (400) @(posedge clk);
    `CHECK(conversionResult, 24'h5A3C96, "continuous result")
    rd(ADR_RESULT, rdat); `CHECK(rdat, 32'h005A3C96, "result reg")
    wr(ADR_INPUT, 16'h0000);
    `CHECK(conversionResult, 24'h000000, "disable result")
    `CHECK(conversionCounter, 2'h0, "disable counter")
    wr(ADR_SETUP, 16'h0800);
    wr(ADR_INPUT, 16'h8000);
    repeat (400) @(posedge clk);
    `CHECK(conversionCounter, 2'h0, "single shot idle")
    for (int k = 1; k < 3; k++)
    begin
      wr(ADR_CTRL, 16'h0001);
      repeat (400) @(posedge clk);
      `CHECK(conversionCounter, 2'(k), "single shot count")
    end
    rd(ADR_STATUS, rdat); `CHECK(rdat, 32'h00000004, "status")
    @(posedge clk);
    standby <= 1'b1;
    repeat (3) @(posedge clk);
    `CHECK(conversionResult, 24'h000000, "standby result")
    `CHECK(conversionCounter, 2'h0, "standby counter")
    standby <= 1'b0;
  endtask : test_conversion

  // The one place where the run ends.
  task automatic print_verdict();
    if (miscompares == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // Main sequence: six cycles of reset, then the scenarios in turn.
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_setup();
    test_input();
    test_trim();
    test_conversion();
    print_verdict();
  end

  // Watchdog well beyond the roughly 1800 cycles the scenarios need.
  initial
  begin
    #(50 * 20000);
    miscompares++;
    print_verdict();
  end

endmodule : testbench
`default_nettype wire
